// [rtl/belv_addr_capture.sv]
// belv_addr_capture: follows secondary bus address phases.
// assumes bus pins already synchronous to clk_sys.
`timescale 1ns/100ps
module belv_addr_capture
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // secondary bus pins
  input  wire logic        pci_frame_n,
  input  wire logic [31:0] pci_ad,
  input  wire logic [3:0]  pci_cbe_n,
  // captured cycle
  output logic      [31:0] cap_addr_lo,
  output logic      [31:0] cap_addr_hi,
  output logic      [3:0]  cap_cmd_lo,
  output logic      [3:0]  cap_cmd_hi,
  output logic             cap_dual
);

  import belv_pkg::*;

  typedef enum logic [2:0] {
    BELV_CAP_IDLE = 3'b001,
    BELV_CAP_DAC  = 3'b010,
    BELV_CAP_DATA = 3'b100
  } belv_cap_state_t;

  belv_cap_state_t state_q, state_d;
  logic [31:0] lo_q, lo_d, hi_q, hi_d;
  logic [3:0]  clo_q, clo_d, chi_q, chi_d;
  logic        dual_q, dual_d;

  // ----------------------------------------------------------------
  // phase tracking
  // ----------------------------------------------------------------
  // first phase is the cycle frame falls; a dual cycle adds one more
  always_comb
  begin
    state_d = state_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    clo_d   = clo_q;
    chi_d   = chi_q;
    dual_d  = dual_q;
    case (state_q)
      BELV_CAP_IDLE:
      begin
        if (!pci_frame_n)
        begin
          lo_d   = pci_ad;
          clo_d  = pci_cbe_n;
          hi_d   = BELV_LOG_RESET;   // 32-bit address leaves top zero
          chi_d  = BELV_CMD_RESET;
          dual_d = (pci_cbe_n == BELV_CMD_DAC);
          state_d = (pci_cbe_n == BELV_CMD_DAC) ? BELV_CAP_DAC
                                                : BELV_CAP_DATA;
        end
      end
      BELV_CAP_DAC:
      begin
        hi_d    = pci_ad;
        chi_d   = pci_cbe_n;
        state_d = BELV_CAP_DATA;
      end
      BELV_CAP_DATA:
      begin
        if (pci_frame_n)
          state_d = BELV_CAP_IDLE;
      end
      default: state_d = BELV_CAP_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= BELV_CAP_IDLE;
      lo_q    <= BELV_LOG_RESET;
      hi_q    <= BELV_LOG_RESET;
      clo_q   <= BELV_CMD_RESET;
      chi_q   <= BELV_CMD_RESET;
      dual_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      clo_q   <= clo_d;
      chi_q   <= chi_d;
      dual_q  <= dual_d;
    end
  end

  assign cap_addr_lo = lo_q;
  assign cap_addr_hi = hi_q;
  assign cap_cmd_lo  = clo_q;
  assign cap_cmd_hi  = chi_q;
  assign cap_dual    = dual_q;

endmodule : belv_addr_capture

// [rtl/belv_error_log_vc.sv]
// belv_error_log_vc: error header log and channel capability registers,
// plus the upstream channel arbiter that the strict priority control steers.
// assumes configuration requests are one-cycle pulses on clk_sys and
// that link reset, global reset pin and power-on reset are synchronous.
`timescale 1ns/100ps

// Notes on behaviour
// - on an error, log the failing cycle's address and command
// - log reads as four words, 13c low bits up to 148 high bits
// - first address phase goes to bits 95:64, second to 127:96
// - single address cycle leaves logged bits 127:96 at zero
// - command lines of first address phase land in bits 39:36
// - command lines of second address phase land in bits 43:40
// - attribute bits 35:0 and reserved bits 63:44 read zero
// - link reset, global reset pin and power-on reset clear the log
// - word at 150 identifies the virtual channel capability, 0002
// - next pointer zero and version one at 152
// - arbitration table entry size field reads 10b
// - reference clock field reads 00b, internal fixed tick
// - low priority count reads 001b, or 000b under strict priority
// - strict priority always grants the extended channel first
// - extended channel count reads 001b
// - reserved bits 31:12 of port capability one read zero
module belv_error_log_vc
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  // other reset sources
  input  wire logic                         link_rst,
  input  wire logic                         global_reset_pin,
  input  wire logic                         por_rst,
  // configuration access
  input  wire logic                         cfg_rd_req,
  input  wire logic                         cfg_wr_req,
  input  wire logic [belv_pkg::BELV_AW-1:0] cfg_addr,
  input  wire logic [belv_pkg::BELV_DW-1:0] cfg_wdata,
  input  wire logic [3:0]                   cfg_be,
  output logic                              cfg_ack,
  output logic      [belv_pkg::BELV_DW-1:0] cfg_rdata,
  // secondary bus monitor
  input  wire logic                         pci_frame_n,
  input  wire logic [31:0]                  pci_ad,
  input  wire logic [3:0]                   pci_cbe_n,
  input  wire logic                         err_detect,
  // channel control and arbitration
  input  wire logic                         strict_priority_en,
  input  wire logic                         vc0_req,
  input  wire logic                         ext_req,
  output logic                              vc0_gnt,
  output logic                              ext_gnt
);

  import belv_pkg::*;

  typedef enum logic [1:0] {
    BELV_LAST_VC0 = 2'b01,
    BELV_LAST_EXT = 2'b10
  } belv_arb_state_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] cap_addr_lo, cap_addr_hi;
  logic [3:0]  cap_cmd_lo, cap_cmd_hi;
  logic        cap_dual;

  logic [31:0] addr_lo_q, addr_lo_d, addr_hi_q, addr_hi_d;
  logic [3:0]  cmd_lo_q, cmd_lo_d, cmd_hi_q, cmd_hi_d;
  logic        log_clear;

  logic             ack_q, ack_d;
  logic [31:0]      rdata_q, rdata_d;
  belv_arb_state_t  last_q, last_d;

  // data written by software is never stored anywhere
  logic        wr_seen;
  assign wr_seen = cfg_wr_req & (|cfg_be) & (|cfg_wdata | ~|cfg_wdata);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word 1 of the log: command fields, the rest reads zero
  function automatic logic [31:0] belv_cmd_word(input logic [3:0] lo,
                                                input logic [3:0] hi);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BELV_CMD_LO_POS +: 4] = lo;
    w[BELV_CMD_HI_POS +: 4] = hi;
    return w;
  endfunction : belv_cmd_word

  // port capability one, live with the strict priority control
  function automatic logic [31:0] belv_port_cap1(input logic strict);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BELV_TABLE_SIZE_POS +: 2] = BELV_TABLE_SIZE_VAL;
    w[BELV_REF_CLK_POS +: 2]    = BELV_REF_CLK_VAL;
    w[BELV_LOW_CNT_POS +: 3]    = strict ? BELV_LOW_CNT_STRICT
                                         : BELV_LOW_CNT_NORMAL;
    w[BELV_EXT_COUNT_POS +: 3]  = BELV_EXT_COUNT_VAL;
    return w;
  endfunction : belv_port_cap1

  // ----------------------------------------------------------------
  // address phase tracker
  // ----------------------------------------------------------------
  belv_addr_capture belv_addr_capture_inst (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .pci_frame_n (pci_frame_n),
    .pci_ad      (pci_ad),
    .pci_cbe_n   (pci_cbe_n),
    .cap_addr_lo (cap_addr_lo),
    .cap_addr_hi (cap_addr_hi),
    .cap_cmd_lo  (cap_cmd_lo),
    .cap_cmd_hi  (cap_cmd_hi),
    .cap_dual    (cap_dual)
  );

  // ----------------------------------------------------------------
  // header log
  // ----------------------------------------------------------------
  // any of the three resets clears; clear beats a same-cycle error
  assign log_clear = link_rst | global_reset_pin | por_rst;

  always_comb
  begin
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    cmd_lo_d  = cmd_lo_q;
    cmd_hi_d  = cmd_hi_q;
    if (log_clear)
    begin
      addr_lo_d = BELV_LOG_RESET;
      addr_hi_d = BELV_LOG_RESET;
      cmd_lo_d  = BELV_CMD_RESET;
      cmd_hi_d  = BELV_CMD_RESET;
    end
    else if (err_detect)
    begin
      // newest error always overwrites the previous record
      addr_lo_d = cap_addr_lo;
      addr_hi_d = cap_dual ? cap_addr_hi : 32'h0000_0000;
      cmd_lo_d  = cap_cmd_lo;
      cmd_hi_d  = cap_dual ? cap_cmd_hi : BELV_CMD_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_lo_q <= BELV_LOG_RESET;
      addr_hi_q <= BELV_LOG_RESET;
      cmd_lo_q  <= BELV_CMD_RESET;
      cmd_hi_q  <= BELV_CMD_RESET;
    end
    else
    begin
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      cmd_lo_q  <= cmd_lo_d;
      cmd_hi_q  <= cmd_hi_d;
    end
  end

  // ----------------------------------------------------------------
  // configuration access
  // ----------------------------------------------------------------
  // every request acked next cycle; writes are dropped on purpose
  always_comb
  begin
    ack_d   = cfg_rd_req | wr_seen | cfg_wr_req;
    rdata_d = 32'h0000_0000;  // write data is never stored
    if (cfg_rd_req)
    begin
      if (cfg_addr == BELV_OFF_LOG_WORD0)
        rdata_d = 32'h0000_0000;
      else if (cfg_addr == BELV_OFF_LOG_WORD1)
        rdata_d = belv_cmd_word(cmd_lo_q, cmd_hi_q);
      else if (cfg_addr == BELV_OFF_LOG_WORD2)
        rdata_d = addr_lo_q;
      else if (cfg_addr == BELV_OFF_LOG_WORD3)
        rdata_d = addr_hi_q;
      else if (cfg_addr == BELV_OFF_CAP_ID)
        rdata_d = {BELV_NEXT_VER_VAL, BELV_CAP_ID_VAL};
      else if (cfg_addr == BELV_OFF_PORT_CAP1)
        rdata_d = belv_port_cap1(strict_priority_en);
      else
        rdata_d = 32'h0000_0000;  // unmapped reads zero
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack   = ack_q;
  assign cfg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // upstream channel arbiter
  // ----------------------------------------------------------------
  // grants are combinational so a request is served the same cycle;
  // without strict priority the two channels alternate when both ask
  always_comb
  begin
    vc0_gnt = 1'b0;
    ext_gnt = 1'b0;
    if (strict_priority_en)
    begin
      ext_gnt = ext_req;
      vc0_gnt = vc0_req & ~ext_req;
    end
    else
    begin
      case (last_q)
        BELV_LAST_VC0:
        begin
          ext_gnt = ext_req;
          vc0_gnt = vc0_req & ~ext_req;
        end
        BELV_LAST_EXT:
        begin
          vc0_gnt = vc0_req;
          ext_gnt = ext_req & ~vc0_req;
        end
        default:
        begin
          vc0_gnt = vc0_req;
          ext_gnt = 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    last_d = last_q;
    if (ext_gnt)
      last_d = BELV_LAST_EXT;
    else if (vc0_gnt)
      last_d = BELV_LAST_VC0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      last_q <= BELV_LAST_VC0;
    else
      last_q <= last_d;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking belv_cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_ack_next_cycle: assert property (
    (cfg_rd_req | cfg_wr_req) |=> cfg_ack)
    else $error("request not acked next cycle");

  a_error_overwrite: assert property (
    (err_detect && !log_clear) |=>
      (addr_lo_q == $past(cap_addr_lo)) && (cmd_lo_q == $past(cap_cmd_lo)))
    else $error("error cycle not logged");

  a_word_order: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_LOG_WORD3) |=>
      cfg_rdata == $past(addr_hi_q))
    else $error("top log word wrong");

  a_first_phase: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_LOG_WORD2) |=>
      cfg_rdata == $past(addr_lo_q))
    else $error("first address phase word wrong");

  a_single_addr_zero: assert property (
    (err_detect && !cap_dual && !log_clear) |=>
      addr_hi_q == 32'h0000_0000 ##1 1'b1)
    else $error("upper address not zeroed");

  a_cmd_fields: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_LOG_WORD1) |=>
      (cfg_rdata[7:4] == $past(cmd_lo_q)) &&
      (cfg_rdata[11:8] == $past(cmd_hi_q)))
    else $error("command fields misplaced");

  a_dual_upper_cmd: assert property (
    (err_detect && cap_dual && !log_clear) |=>
      cmd_hi_q == $past(cap_cmd_hi))
    else $error("upper command not logged");

  a_reserved_zero: assert property (
    (cfg_rd_req && (cfg_addr == BELV_OFF_LOG_WORD0 ||
                    cfg_addr == BELV_OFF_LOG_WORD1)) |=>
      (cfg_rdata[31:12] == 20'h0_0000) && (cfg_rdata[3:0] == 4'h0))
    else $error("reserved log bits not zero");

  a_clear_log: assert property (
    log_clear |=> (addr_lo_q == 32'h0000_0000) &&
      (addr_hi_q == 32'h0000_0000) && (cmd_lo_q == 4'h0) &&
      (cmd_hi_q == 4'h0))
    else $error("log not cleared");

  a_cap_id_word: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_CAP_ID) |=>
      cfg_rdata == 32'h0001_0002)
    else $error("capability header wrong");

  a_port_cap_value: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_PORT_CAP1 && !strict_priority_en)
      |=> cfg_rdata == 32'h0000_0811)
    else $error("port capability one wrong");

  a_low_count_strict: assert property (
    (cfg_rd_req && cfg_addr == BELV_OFF_PORT_CAP1 && strict_priority_en)
      |=> cfg_rdata[6:4] == 3'b000)
    else $error("low priority count wrong under strict");

  a_strict_grant: assert property (
    (strict_priority_en && ext_req) |-> (ext_gnt && !vc0_gnt))
    else $error("extended channel not first");

  a_write_ignored: assert property (
    (cfg_wr_req && !cfg_rd_req && !err_detect && !log_clear) |=>
      $stable(addr_lo_q) && $stable(addr_hi_q) && $stable(cmd_lo_q) &&
      (cfg_rdata == 32'h0000_0000))
    else $error("write changed state");

endmodule : belv_error_log_vc

// [rtl/belv_pkg.sv]
// belv_pkg: constants for the bridge error log and channel capability bank.
// assumes byte addresses of the extended configuration space, 12 bits wide.
package belv_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int BELV_AW = 12;
  localparam int BELV_DW = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, dword aligned except BELV_OFF_NEXT_VER at 152)
  // ----------------------------------------------------------------
  localparam logic [11:0] BELV_OFF_LOG_WORD0 = 12'h13c;
  localparam logic [11:0] BELV_OFF_LOG_WORD1 = 12'h140;
  localparam logic [11:0] BELV_OFF_LOG_WORD2 = 12'h144;
  localparam logic [11:0] BELV_OFF_LOG_WORD3 = 12'h148;
  localparam logic [11:0] BELV_OFF_CAP_ID    = 12'h150;
  localparam logic [11:0] BELV_OFF_NEXT_VER  = 12'h152;
  localparam logic [11:0] BELV_OFF_PORT_CAP1 = 12'h154;

  // ----------------------------------------------------------------
  // log field positions inside word 1 (bits 63:32 of the log)
  // ----------------------------------------------------------------
  localparam int BELV_CMD_LO_POS = 4;   // log bits 39:36
  localparam int BELV_CMD_HI_POS = 8;   // log bits 43:40

  // ----------------------------------------------------------------
  // field positions inside port capability one
  // ----------------------------------------------------------------
  localparam int BELV_TABLE_SIZE_POS = 10;  // bits 11:10
  localparam int BELV_REF_CLK_POS    = 8;   // bits 9:8
  localparam int BELV_LOW_CNT_POS    = 4;   // bits 6:4
  localparam int BELV_EXT_COUNT_POS  = 0;   // bits 2:0

  // ----------------------------------------------------------------
  // read-only values
  // ----------------------------------------------------------------
  localparam logic [15:0] BELV_CAP_ID_VAL     = 16'h0002;
  localparam logic [15:0] BELV_NEXT_VER_VAL   = 16'h0001;
  localparam logic [1:0]  BELV_TABLE_SIZE_VAL = 2'h2;
  localparam logic [1:0]  BELV_REF_CLK_VAL    = 2'h0;
  localparam logic [2:0]  BELV_LOW_CNT_NORMAL = 3'h1;
  localparam logic [2:0]  BELV_LOW_CNT_STRICT = 3'h0;
  localparam logic [2:0]  BELV_EXT_COUNT_VAL  = 3'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] BELV_LOG_RESET  = 32'h0000_0000;
  localparam logic [3:0]  BELV_CMD_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // bus command marking a dual address cycle
  // ----------------------------------------------------------------
  localparam logic [3:0]  BELV_CMD_DAC = 4'hd;

endpackage : belv_pkg

// [test/belv_bus_master_model.sv]
// belv_bus_master_model: behavioural secondary bus master for the bank.
// assumes the bench calls run_cycle from its clocked main sequence.
`timescale 1ns/100ps
module belv_bus_master_model
(
  // clock
  input  wire logic        clk_sys,
  // secondary bus pins
  output logic             pci_frame_n,
  output logic      [31:0] pci_ad,
  output logic      [3:0]  pci_cbe_n
);
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    pci_frame_n = 1'b1;
    pci_ad      = 32'h0000_0000;
    pci_cbe_n   = 4'hf;
  end

  // ----------------------------------------------------------------
  // one bus cycle: address phase(s), one data phase, then release
  // ----------------------------------------------------------------
  // released lines show the inverse of their last value, so a design
  // that samples outside the address phase cannot pass by luck
  task automatic run_cycle(input logic [31:0] lo, input logic [31:0] hi,
                           input logic [3:0] clo, input logic [3:0] chi,
                           input bit dual);
    @(posedge clk_sys);
    pci_frame_n <= 1'b0;
    pci_ad      <= lo;
    pci_cbe_n   <= clo;
    if (dual)
    begin
      @(posedge clk_sys);
      pci_ad    <= hi;
      pci_cbe_n <= chi;
    end
    @(posedge clk_sys);
    pci_ad      <= 32'h5a5a_5a5a;
    pci_cbe_n   <= 4'h0;
    @(posedge clk_sys);
    pci_frame_n <= 1'b1;
    pci_ad      <= 32'ha5a5_a5a5;
    pci_cbe_n   <= 4'hf;
  endtask : run_cycle

endmodule : belv_bus_master_model

// [test/belv_error_log_vc_test.sv]
// belv_error_log_vc_test: self-checking bench for the log and capability bank.
// assumes single-cycle config requests answered one cycle later.
`timescale 1ns/100ps
module belv_error_log_vc_test;
  import belv_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk_sys = 1'b0;
  logic               sys_rst, link_rst, global_reset_pin, por_rst;
  logic               cfg_rd_req, cfg_wr_req, cfg_ack;
  logic [BELV_AW-1:0] cfg_addr;
  logic [BELV_DW-1:0] cfg_wdata, cfg_rdata;
  logic [3:0]         cfg_be, pci_cbe_n;
  logic               pci_frame_n, err_detect, strict_priority_en;
  logic               vc0_req, ext_req, vc0_gnt, ext_gnt;
  logic [31:0]        pci_ad;
  int                 mismatches = 0;
  int                 checked = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  belv_error_log_vc belv_error_log_vc_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link_rst(link_rst),
    .global_reset_pin(global_reset_pin), .por_rst(por_rst),
    .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .pci_frame_n(pci_frame_n), .pci_ad(pci_ad), .pci_cbe_n(pci_cbe_n),
    .err_detect(err_detect), .strict_priority_en(strict_priority_en),
    .vc0_req(vc0_req), .ext_req(ext_req),
    .vc0_gnt(vc0_gnt), .ext_gnt(ext_gnt)
  );

  belv_bus_master_model belv_bus_master_model_inst (
    .clk_sys(clk_sys), .pci_frame_n(pci_frame_n),
    .pci_ad(pci_ad), .pci_cbe_n(pci_cbe_n)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : check

  // one request pulse; answer is due right after the taking edge
  task automatic access(input bit wr, input logic [11:0] a,
                        output logic [31:0] d);
    @(posedge clk_sys);
    cfg_rd_req <= !wr;
    cfg_wr_req <= wr;
    cfg_addr   <= a;
    cfg_wdata  <= 32'hffff_ffff;
    cfg_be     <= 4'hf;
    @(posedge clk_sys);
    cfg_rd_req <= 1'b0;
    cfg_wr_req <= 1'b0;
    #1;
    check({31'h0, cfg_ack}, 32'h0000_0001);
    d = cfg_rdata;
  endtask : access

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    access(1'b0, a, d);
    check(d, exp);
  endtask : rd_chk

  // expected log image built field by field
  function automatic logic [127:0] exp_log(input logic [31:0] lo,
    input logic [31:0] hi, input logic [3:0] clo, input logic [3:0] chi,
    input bit dual);
    return {dual ? hi : 32'h0000_0000, lo, 20'h0_0000,
            dual ? chi : 4'h0, clo, 4'h0, 32'h0000_0000};
  endfunction : exp_log

  task automatic chk_log(input logic [127:0] exp);
    for (int i = 0; i < 4; i++)
      rd_chk(BELV_OFF_LOG_WORD0 + 12'(4 * i), exp[32 * i +: 32]);
  endtask : chk_log

  // bus cycle followed by an error pulse one cycle after release
  task automatic log_cycle(input logic [31:0] lo, input logic [31:0] hi,
                           input logic [3:0] clo, input logic [3:0] chi,
                           input bit dual);
    belv_bus_master_model_inst.run_cycle(lo, hi, clo, chi, dual);
    @(posedge clk_sys);
    err_detect <= 1'b1;
    @(posedge clk_sys);
    err_detect <= 1'b0;
  endtask : log_cycle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idle_values;
    chk_log(128'h0);
    rd_chk(BELV_OFF_CAP_ID, 32'h0001_0002);
    rd_chk(BELV_OFF_PORT_CAP1, 32'h0000_0811);
    rd_chk(12'h160, 32'h0000_0000);
  endtask : t_idle_values

  // dual then single: the single one must wipe the old upper address
  task automatic t_log_overwrite;
    logic [127:0] e;
    log_cycle(32'h1234_5678, 32'h0000_00ab, BELV_CMD_DAC, 4'h6, 1'b1);
    e = exp_log(32'h1234_5678, 32'h0000_00ab, BELV_CMD_DAC, 4'h6, 1'b1);
    chk_log(e);
    log_cycle(32'h8765_4320, 32'hffff_ffff, 4'h7, 4'h3, 1'b0);
    e = exp_log(32'h8765_4320, 32'hffff_ffff, 4'h7, 4'h3, 1'b0);
    chk_log(e);
    belv_bus_master_model_inst.run_cycle(32'hcafe_0000, 32'h0000_0001,
                                         4'h6, 4'h0, 1'b0);
    chk_log(e);
  endtask : t_log_overwrite

  task automatic t_clear;
    for (int k = 0; k < 3; k++)
    begin
      log_cycle(32'h0bad_f00c, 32'h0000_1234, BELV_CMD_DAC, 4'h2, 1'b1);
      @(posedge clk_sys);
      link_rst         <= (k == 0);
      global_reset_pin <= (k == 1);
      por_rst          <= (k == 2);
      @(posedge clk_sys);
      link_rst         <= 1'b0;
      global_reset_pin <= 1'b0;
      por_rst          <= 1'b0;
      chk_log(128'h0);
    end
  endtask : t_clear

  task automatic t_write_ignored;
    logic [11:0] offs [6] = '{12'h13c, 12'h140, 12'h144, 12'h148,
                               12'h150, 12'h154};
    logic [31:0] d;
    log_cycle(32'h00c0_ffee, 32'h7777_0000, BELV_CMD_DAC, 4'h9, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      access(1'b1, offs[i], d);
      check(d, 32'h0000_0000);
    end
    chk_log(exp_log(32'h00c0_ffee, 32'h7777_0000, BELV_CMD_DAC,
                    4'h9, 1'b1));
    rd_chk(BELV_OFF_CAP_ID, 32'h0001_0002);
    rd_chk(BELV_OFF_PORT_CAP1, 32'h0000_0811);
  endtask : t_write_ignored

  // both channels asking: strict mode must never hand over to vc0
  task automatic t_strict;
    @(posedge clk_sys);
    strict_priority_en <= 1'b1;
    vc0_req            <= 1'b1;
    ext_req            <= 1'b1;
    rd_chk(BELV_OFF_PORT_CAP1, 32'h0000_0801);
    repeat (4)
    begin
      @(posedge clk_sys);
      #1;
      check({30'h0, ext_gnt, vc0_gnt}, 32'h0000_0002);
    end
    @(posedge clk_sys);
    strict_priority_en <= 1'b0;
    vc0_req            <= 1'b0;
    ext_req            <= 1'b0;
    rd_chk(BELV_OFF_PORT_CAP1, 32'h0000_0811);
  endtask : t_strict

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // hang guard, far beyond the length of the normal run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial
  begin
    sys_rst            = 1'b1;
    link_rst           = 1'b0;
    global_reset_pin   = 1'b0;
    por_rst            = 1'b0;
    cfg_rd_req         = 1'b0;
    cfg_wr_req         = 1'b0;
    cfg_addr           = 12'h000;
    cfg_wdata          = 32'h0000_0000;
    cfg_be             = 4'h0;
    err_detect         = 1'b0;
    strict_priority_en = 1'b0;
    vc0_req            = 1'b0;
    ext_req            = 1'b0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_idle_values();
    t_log_overwrite();
    t_clear();
    t_write_ignored();
    t_strict();
    close_out();
  end

endmodule : belv_error_log_vc_test
